// >>> rtl/nvss_top.sv
`timescale 1ns/1ps
module nvss_top #(
  parameter int LOCKOUT_CYCLES = nvss_pkg::LOCKOUT_CYC  // busy time after commit
) (
  // core clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // two-wire bus; scl clocks the link logic
  input  wire logic       scl_clk,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // strap and control pins
  input  wire logic       slave_address_select_0,
  input  wire logic       slave_address_select_1,
  input  wire logic       write_protect_pin,
  input  wire logic       output_source_select_pin,
  input  wire logic [5:0] external_setting_inputs,
  // open-drain outputs
  output logic [5:0]      selected_open_drain_outputs_o,
  output logic [5:0]      selected_open_drain_outputs_oe
);

  // *****************************************************************
  // core domain: pin synchronisers, settings, output mux
  // *****************************************************************
  typedef struct packed {
    logic [1:0]        adr0_s;     // address pin sync
    logic [1:0]        adr1_s;
    logic [1:0]        wp_s;       // write protect sync
    logic [1:0]        sel_s;      // select pin sync
    logic [5:0]        in_s1;      // input pins stage 1
    logic [5:0]        in_s2;      // input pins stage 2
    logic [2:0]        cm_tog_s;   // commit toggle sync plus edge history
    logic [2:0]        src_tog_s;  // source change toggle sync
    logic [5:0]        set0;       // setting bytes
    logic [5:0]        set1;
    logic [5:0]        set2;
    logic [5:0]        set3;
    nvss_pkg::nvss_src_t src;      // output source mode
    logic [1:0]        src_idx;    // setting byte for output
    logic [31:0]       busy_cnt;   // lockout counter
    logic              busy;       // address lockout
    logic [5:0]        od_q;       // output values
  } nvss_core_t;

  nvss_core_t           c_q;        // core state
  nvss_core_t           c_d;        // next core state
  nvss_pkg::nvss_commit_t cm_q;     // link side commit record, held steady
  logic                 src_tog_q;  // link side source toggle
  nvss_pkg::nvss_src_t  src_req_q;  // requested mode, stable across toggle
  logic [1:0]           src_idx_q;  // requested byte, stable across toggle
  logic [5:0]           rd_word;    // word selected by the read pointer
  logic [7:0]           rd_ptr;     // link side pointer, read combinationally

  // setting byte lookup, used by reads and output mux
  function automatic logic [5:0] pick(input nvss_core_t s, input logic [1:0] i);
    case (i)
      2'h0:    pick = s.set0;
      2'h1:    pick = s.set1;
      2'h2:    pick = s.set2;
      default: pick = s.set3;
    endcase
  endfunction

  // core next state
  always_comb begin
    logic [5:0] wd;  // word being committed
    logic [1:0] wi;  // index being committed
    wd = 6'h00;
    wi = 2'h0;
    c_d = c_q;
    c_d.adr0_s = {c_q.adr0_s[0], slave_address_select_0};
    c_d.adr1_s = {c_q.adr1_s[0], slave_address_select_1};
    c_d.wp_s   = {c_q.wp_s[0], write_protect_pin};
    c_d.sel_s  = {c_q.sel_s[0], output_source_select_pin};
    c_d.in_s1  = external_setting_inputs;
    c_d.in_s2  = c_q.in_s1;
    c_d.cm_tog_s  = {c_q.cm_tog_s[1:0], cm_q.toggle};
    c_d.src_tog_s = {c_q.src_tog_s[1:0], src_tog_q};
    // lockout countdown
    if (c_q.busy_cnt != 32'h0) begin
      c_d.busy_cnt = c_q.busy_cnt - 32'h1;
    end else begin
      c_d.busy = 1'b0;
    end
    // commit request: record is stable since toggle passed two flops
    if (c_q.cm_tog_s[2] != c_q.cm_tog_s[1]) begin
      for (int k = 0; k < nvss_pkg::MAX_WR_BYTES; k++) begin
        if (k[1:0] <= cm_q.count) begin
          wi = cm_q.first + k[1:0];
          case (k)
            0:       wd = cm_q.data0;
            1:       wd = cm_q.data1;
            2:       wd = cm_q.data2;
            default: wd = cm_q.data3;
          endcase
          case (wi)
            2'h0:    c_d.set0 = wd;
            2'h1:    c_d.set1 = wd;
            2'h2:    c_d.set2 = wd;
            default: c_d.set3 = wd;
          endcase
        end
      end
      c_d.busy     = 1'b1;
      c_d.busy_cnt = 32'(LOCKOUT_CYCLES);
    end
    // source change from a command byte
    if (c_q.src_tog_s[2] != c_q.src_tog_s[1]) begin
      c_d.src     = src_req_q;
      c_d.src_idx = src_idx_q;
    end
    // output mux
    case (c_q.src)
      nvss_pkg::NVSS_SRC_PINS: c_d.od_q = c_q.in_s2;
      nvss_pkg::NVSS_SRC_BYTE: c_d.od_q = pick(c_q, c_q.src_idx);
      default: c_d.od_q = c_q.sel_s[1] ? c_q.in_s2 : pick(c_q, c_q.src_idx);
    endcase
  end

  // core register; settings reset to zero, source to byte 0 under select pin
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      c_q          <= '0;
      c_q.set0     <= nvss_pkg::SETTING_RESET;
      c_q.set1     <= nvss_pkg::SETTING_RESET;
      c_q.set2     <= nvss_pkg::SETTING_RESET;
      c_q.set3     <= nvss_pkg::SETTING_RESET;
      c_q.src      <= nvss_pkg::NVSS_SRC_PIN_SEL;
      c_q.src_idx  <= 2'h0;
    end else begin
      c_q <= c_d;
    end
  end

  // open drain: pull low for zero, release for one
  assign selected_open_drain_outputs_o  = 6'h00;
  assign selected_open_drain_outputs_oe = ~c_q.od_q;

  // *****************************************************************
  // link domain: bit engine on scl
  // *****************************************************************
  typedef enum logic [4:0] {
    L_IDLE = 5'b00001,  // waiting for start
    L_ADDR = 5'b00010,  // shifting address
    L_WDAT = 5'b00100,  // shifting written byte
    L_RDAT = 5'b01000,  // driving read byte
    L_ACK  = 5'b10000   // ack slot
  } nvss_lst_t;

  typedef struct packed {
    nvss_lst_t  st;
    logic [2:0] bit_n;    // bit counter
    logic [7:0] sh;       // shift register
    logic       ack;      // drive ack in ack slot
    logic       rd;       // current transfer reads
    logic       ctl_done; // control byte taken
    logic       cmd;      // control held a command code
    logic       dead;     // refuse rest of transfer
    logic [2:0] nbytes;   // data bytes taken
    logic [7:0] ptr;      // pointer
    logic       mack;     // master acked last read byte
  } nvss_link_t;

  nvss_link_t l_q;
  nvss_link_t l_d;
  logic       start_tog;  // start seen, toggled on sda fall (scl high)
  logic       start_q;    // copy of start_tog taken on each rising scl
  logic       sda_oe_d;   // sda drive wanted, moved to the line on falling scl
  logic       busy_l1;    // lockout sync stage 1
  logic       busy_l2;    // lockout sync stage 2
  logic [1:0] wp_l;       // protect pin into scl domain
  logic [5:0] pend [4];   // pending data bytes
  logic [1:0] pend_first; // first index of pending burst
  logic       pend_ok;    // burst still allowed to commit
  logic [2:0] pend_n_q;   // copy of count seen at last scl edge

  // start detect: sda falling while scl high; only toggles, so the first
  // scl rise of the frame already sees it and takes the address msb
  always_ff @(negedge sda_i) begin
    if (sys_rst) begin
      start_tog <= 1'b0;
    end else if (scl_clk) begin
      start_tog <= ~start_tog;
    end
  end

  // read data word
  assign rd_ptr  = l_q.ptr;
  assign rd_word = (rd_ptr == nvss_pkg::PTR_SNAPSHOT) ? c_q.in_s2 : pick(c_q, rd_ptr[1:0]);

  // link next state, evaluated on each rising scl edge
  always_comb begin
    logic [7:0] by;     // completed byte
    logic       adr_ok; // address matches and no lockout
    by     = {l_q.sh[6:0], sda_i};
    adr_ok = 1'b0;
    l_d    = l_q;
    if (start_q != start_tog) begin
      l_d.st       = L_ADDR;
      l_d.bit_n    = 3'h1;
      l_d.sh       = {7'h00, sda_i};
      l_d.ctl_done = 1'b0;
      l_d.dead     = 1'b0;
      l_d.nbytes   = 3'h0;
    end else begin
      case (l_q.st)
        L_ADDR: begin
          l_d.sh    = by;
          l_d.bit_n = l_q.bit_n + 3'h1;
          if (l_q.bit_n == 3'h7) begin
            adr_ok = (by[7:3] == nvss_pkg::ADDR_FIXED) &&
                     (by[2:1] == {c_q.adr1_s[1], c_q.adr0_s[1]}) && !busy_l2;
            l_d.rd  = by[0];
            l_d.ack = adr_ok;
            l_d.st  = adr_ok ? L_ACK : L_IDLE;
          end
        end
        L_WDAT: begin
          l_d.sh    = by;
          l_d.bit_n = l_q.bit_n + 3'h1;
          if (l_q.bit_n == 3'h7) begin
            l_d.st = L_ACK;
            if (!l_q.ctl_done) begin
              l_d.ctl_done = 1'b1;
              l_d.ack = (by <= nvss_pkg::PTR_SET3) || (by == nvss_pkg::PTR_SNAPSHOT) ||
                        (by[7:4] == nvss_pkg::CMD_NIBBLE && by[1:0] != 2'b11);
              l_d.cmd = (by[7:4] == nvss_pkg::CMD_NIBBLE) && (by != nvss_pkg::PTR_SNAPSHOT);
              if (l_d.ack && !l_d.cmd) begin
                l_d.ptr = by;
              end
            end else begin
              l_d.ack = !l_q.cmd && !wp_l[1] && l_q.ptr != nvss_pkg::PTR_SNAPSHOT &&
                        l_q.nbytes < 3'(nvss_pkg::MAX_WR_BYTES) && !l_q.dead;
              if (l_q.nbytes >= 3'(nvss_pkg::MAX_WR_BYTES)) begin
                l_d.dead = 1'b1;
              end
              if (l_d.ack) begin
                l_d.nbytes = l_q.nbytes + 3'h1;
                l_d.ptr    = {6'h00, l_q.ptr[1:0] + 2'h1};
              end
            end
          end
        end
        L_RDAT: begin
          l_d.bit_n = l_q.bit_n + 3'h1;
          l_d.sh    = {l_q.sh[6:0], 1'b0};
          if (l_q.bit_n == 3'h7) begin
            l_d.st = L_ACK;
            l_d.ack = 1'b0;
            if (l_q.ptr != nvss_pkg::PTR_SNAPSHOT) begin
              l_d.ptr = {6'h00, l_q.ptr[1:0] + 2'h1};
            end
          end
        end
        L_ACK: begin
          l_d.bit_n = 3'h0;
          l_d.mack  = !sda_i;
          if (!l_q.ack && !l_q.rd) begin
            l_d.st = L_IDLE;
          end else if (l_q.rd && (l_q.ctl_done || !sda_i || !l_q.ack)) begin
            l_d.st = (l_q.ack || !sda_i) ? L_RDAT : L_IDLE;
            l_d.ctl_done = 1'b1;
            l_d.sh = {2'b00, rd_word};
          end else begin
            l_d.st = L_WDAT;
          end
        end
        default: l_d.st = L_IDLE;
      endcase
    end
  end

  // link register; start event resets the frame
  always_ff @(posedge scl_clk) begin
    start_q <= start_tog;  // sda settles long before scl rises
    busy_l1 <= c_q.busy;
    busy_l2 <= busy_l1;
    wp_l    <= {wp_l[0], c_q.wp_s[1]};
    if (sys_rst) begin
      l_q       <= '0;
      l_q.st    <= L_IDLE;
      l_q.ptr   <= nvss_pkg::PTR_SET0;
      src_tog_q <= 1'b0;
      src_req_q <= nvss_pkg::NVSS_SRC_PIN_SEL;
      src_idx_q <= 2'h0;
    end else begin
      l_q <= l_d;
      // command byte acked: pass new source to core
      if (l_q.st == L_WDAT && l_q.bit_n == 3'h7 && !l_q.ctl_done && l_d.ack && l_d.cmd) begin
        src_tog_q <= ~src_tog_q;
        src_idx_q <= l_d.sh[3:2];
        src_req_q <= (l_d.sh[1:0] == 2'b10) ? nvss_pkg::NVSS_SRC_PINS :
                     (l_d.sh[0] ? nvss_pkg::NVSS_SRC_PIN_SEL : nvss_pkg::NVSS_SRC_BYTE);
      end
      // collect accepted data bytes
      if (l_q.st == L_WDAT && l_q.bit_n == 3'h7 && l_q.ctl_done && l_d.ack) begin
        pend[l_q.nbytes[1:0]] <= l_d.sh[5:0];
        if (l_q.nbytes == 3'h0) begin
          pend_first <= l_q.ptr[1:0];
        end
      end
      pend_n_q <= l_d.nbytes;
      pend_ok  <= !l_d.dead;
    end
  end

  // commit at stop: stop edge comes with sda rising, scl high, so the
  // record is captured on the stop toggle itself
  always_ff @(posedge sda_i) begin
    if (sys_rst) begin
      cm_q <= '0;
    end else if (scl_clk && pend_ok && pend_n_q != 3'h0) begin
      cm_q.toggle <= ~cm_q.toggle;
      cm_q.count  <= 2'(pend_n_q - 3'h1);
      cm_q.first  <= pend_first;
      cm_q.data0  <= pend[0];
      cm_q.data1  <= pend[1];
      cm_q.data2  <= pend[2];
      cm_q.data3  <= pend[3];
    end
  end

  // sda drive: ack low, read bits low for zero
  always_comb begin
    sda_oe_d = 1'b0;
    if (l_q.st == L_ACK && l_q.ack && !(l_q.rd && l_q.ctl_done)) begin
      sda_oe_d = 1'b1;
    end else if (l_q.st == L_RDAT) begin
      sda_oe_d = !l_q.sh[7];
    end
  end

  // data may only move while scl is low, else it reads as start or stop
  always_ff @(negedge scl_clk) begin
    if (sys_rst) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= sda_oe_d;
    end
  end
  assign sda_o = 1'b0;

  // *****************************************************************
  // checks
  // *****************************************************************
  a_commit_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (c_q.cm_tog_s[2] != c_q.cm_tog_s[1]) |=> c_q.busy)
    else $error("lockout not set after commit");
  a_od_release: assert property (@(posedge ref_clk) disable iff (sys_rst)
    selected_open_drain_outputs_oe == ~c_q.od_q)
    else $error("open drain enable wrong");
  a_pins_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (c_q.src == nvss_pkg::NVSS_SRC_PINS) |=> (c_q.od_q == $past(c_q.in_s2)))
    else $error("pins mode not followed");
  a_sel_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (c_q.src == nvss_pkg::NVSS_SRC_PIN_SEL && c_q.sel_s[1]) |=>
    (c_q.od_q == $past(c_q.in_s2)))
    else $error("select high not followed");
  a_wp_refuse: assert property (@(posedge scl_clk) disable iff (sys_rst)
    (l_q.st == L_ACK && l_q.ctl_done && !l_q.rd && wp_l[1] && l_q.nbytes == 3'h0 &&
     $past(l_q.ctl_done))
    |-> !sda_oe)
    else $error("data acked while protected");
  a_fifth_refuse: assert property (@(posedge scl_clk) disable iff (sys_rst)
    (l_q.st == L_WDAT && l_q.bit_n == 3'h7 && l_q.nbytes == 3'h4) |=> !sda_oe)
    else $error("fifth byte acked");
  a_cmd_refuse: assert property (@(posedge scl_clk) disable iff (sys_rst)
    (l_q.st == L_ACK && l_q.cmd && l_q.ctl_done && l_q.nbytes == 3'h0 && !l_q.rd &&
     $past(l_q.ctl_done)) |-> !sda_oe)
    else $error("data acked after command");
  a_busy_addr: assert property (@(posedge scl_clk) disable iff (sys_rst)
    (l_q.st == L_ADDR && l_q.bit_n == 3'h7 && busy_l2) |=> !sda_oe)
    else $error("address acked while busy");

endmodule // nvss_top

// >>> rtl/nvss_pkg.sv
package nvss_pkg;
  // *****************************************************************
  // bus codes and layouts
  // *****************************************************************
  localparam logic [4:0] ADDR_FIXED     = 5'h0A;  // upper slave address bits, arbitrary
  localparam logic [7:0] PTR_SET0       = 8'h00;  // setting byte 0
  localparam logic [7:0] PTR_SET3       = 8'h03;  // setting byte 3
  localparam logic [7:0] PTR_SNAPSHOT   = 8'hFF;  // input_pin_snapshot
  localparam logic [3:0] CMD_NIBBLE     = 4'hF;   // upper nibble of command codes
  localparam logic [5:0] SETTING_RESET  = 6'h00;  // factory contents
  localparam int         MAX_WR_BYTES   = 4;      // sequential data bytes allowed
  localparam int         CLK_MHZ        = 250;    // ref_clk rate
  localparam int         LOCKOUT_US_X10 = 36;     // busy time, 3.6 ms in 0.1 ms steps
  localparam int         LOCKOUT_CYC    = LOCKOUT_US_X10 * 100 * CLK_MHZ; // cycles

  // output source modes held by the command register
  typedef enum logic [2:0] {
    NVSS_SRC_PIN_SEL = 3'b001,  // select pin chooses pins or setting byte
    NVSS_SRC_BYTE    = 3'b010,  // always setting byte
    NVSS_SRC_PINS    = 3'b100   // always the input pins
  } nvss_src_t;

  // state passed from the link domain into the core domain
  typedef struct packed {
    logic       toggle;     // flips once per commit request
    logic [1:0] count;      // number of bytes to commit minus one
    logic [1:0] first;      // first setting byte index
    logic [5:0] data0;
    logic [5:0] data1;
    logic [5:0] data2;
    logic [5:0] data3;
  } nvss_commit_t;
endpackage

// >>> test/nvss_mst_model.sv
`timescale 1ns/1ps
module nvss_mst_model (
  // bus lines
  output logic      scl_clk,
  output logic      sda_low,
  input  wire logic sda_line
);
  // ********
  // bit timing
  // ********
  localparam int Q = 16;  // quarter of the 64 ns bit time

  // idle bus: clock stands high, data left to the pull-up
  initial begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end

  // one bit; data only moves while the clock is low, else it reads as start or stop
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    #Q scl_clk = 1'b1;
    #Q s = sda_line;
    #Q scl_clk = 1'b0;
    #Q;
  endtask

  // data falls while the clock is high
  task automatic start();
    sda_low = 1'b1;
    #Q scl_clk = 1'b0;
    #Q;
  endtask

  // data rises while the clock is high, then the clock stands still
  task automatic stop();
    sda_low = 1'b1;
    #Q scl_clk = 1'b1;
    #Q sda_low = 1'b0;
    #(2*Q);
  endtask

  // lone clock pulse with data released, so the link logic sees reset
  task automatic pulse();
    #Q scl_clk = 1'b0;
    #(2*Q) scl_clk = 1'b1;
    #Q;
  endtask

  // msb first, then the slave answers in the ninth bit
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // the last byte is refused so the slave lets go of the line
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
endmodule // nvss_mst_model

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  // ********
  // signals
  // ********
  localparam int LOCK = 400;  // shortened busy time, still longer than one address byte
  localparam logic [7:0] RSV [4] = '{8'h04, 8'h7F, 8'hF7, 8'hFB};
  localparam logic [7:0] CMD [9] = '{8'hF0, 8'hF4, 8'hF8, 8'hFC, 8'hF1, 8'hF5, 8'hF9,
                                     8'hFD, 8'hF2};
  localparam logic [6:0] BAD [3] = '{7'h01, 7'h02, 7'h40};
  logic       ref_clk;
  logic       sys_rst;
  logic       wp;
  logic       sel;
  logic [1:0] apin;       // address straps
  logic [5:0] ext;
  logic       scl_clk;
  logic       m_low;      // master pulls data low
  logic       sda_o;
  logic       sda_oe;
  logic [5:0] od_o;
  logic [5:0] od_oe;
  wire logic  sda_line;
  int         errors;
  int         cmp_count;
  logic [5:0] mem [4];    // expected setting bytes
  logic [7:0] wdat [5];
  int         ptr;        // expected pointer, 255 for the snapshot
  int         src;        // 0 select pin, 1 byte, 2 pins
  int         sidx;
  logic [6:0] dev;
  logic       a;

  // pull-up on the data line
  assign sda_line = ~(sda_oe | m_low);

  nvss_top #(.LOCKOUT_CYCLES(LOCK)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_clk(scl_clk), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .slave_address_select_0(apin[0]),
    .slave_address_select_1(apin[1]), .write_protect_pin(wp),
    .output_source_select_pin(sel), .external_setting_inputs(ext),
    .selected_open_drain_outputs_o(od_o), .selected_open_drain_outputs_oe(od_oe));

  nvss_mst_model mst (.scl_clk(scl_clk), .sda_low(m_low), .sda_line(sda_line));

  // 250 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ********
  // helpers
  // ********
  function automatic logic [7:0] exp_rd();
    return (ptr == 255) ? {2'b00, ext} : {2'b00, mem[ptr]};
  endfunction

  function automatic logic [5:0] exp_out();
    return (src == 2 || (src == 0 && sel)) ? ext : mem[sidx];
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic at();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) at();
  endtask

  // pins read through the pull-up: released means one
  task automatic chk_out();
    idle(8);
    chk("outputs", {2'b00, ~od_oe}, {2'b00, exp_out()});
    chk("od_drive", {2'b00, od_o}, 8'h00);
  endtask

  task automatic wr(input logic [7:0] ctl, input int n, input logic ca,
                    input int k, input int gap);
    mst.start();
    mst.send_byte({dev, 1'b0}, a);
    chk("addr_ack", {7'h00, a}, 8'h01);
    mst.send_byte(ctl, a);
    chk("ctl_ack", {7'h00, a}, {7'h00, ca});
    for (int i = 0; i < n; i++) begin
      mst.send_byte(wdat[i], a);
      chk("data_ack", {7'h00, a}, (i < k) ? 8'h01 : 8'h00);
    end
    mst.stop();
    idle(gap);
  endtask

  task automatic setwr(input logic [7:0] ctl);
    wr(ctl, 0, 1'b1, 0, LOCK + 20);
    ptr = int'(ctl);
  endtask

  task automatic rd(input int n);
    logic [7:0] d;
    mst.start();
    mst.send_byte({dev, 1'b1}, a);
    chk("raddr_ack", {7'h00, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      mst.recv_byte(i == n - 1, d);
      chk("rd_data", d, exp_rd());
      if (ptr != 255) ptr = (ptr + 1) % 4;
    end
    mst.stop();
    at();
  endtask

  // reset spans a link clock edge as well
  task automatic do_reset();
    at();
    sys_rst = 1'b1;
    mst.start();
    mst.stop();
    mst.pulse();
    idle(3);
    sys_rst = 1'b0;
    foreach (mem[i]) mem[i] = nvss_pkg::SETTING_RESET;
    ptr = 0;
    src = 0;
    sidx = 0;
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    finish_test();
  end

  // ********
  // main sequence
  // ********
  initial begin
    sys_rst = 1'b1;
    wp = 1'b0;
    sel = 1'b0;
    ext = 6'h00;
    apin = 2'b00;
    errors = 0;
    cmp_count = 0;
    void'($urandom(32'ha1b6));
    apin = 2'($urandom);
    dev = {nvss_pkg::ADDR_FIXED, apin[1], apin[0]};
    do_reset();
    sel = 1'b1;
    ext = 6'($urandom);
    chk_out();
    sel = 1'b0;
    chk_out();
    rd(4);
    foreach (BAD[i]) begin
      mst.start();
      mst.send_byte({dev ^ BAD[i], 1'b0}, a);
      chk("bad_addr", {7'h00, a}, 8'h00);
      mst.stop();
    end
    // full burst wrapping past byte 3, then an early address
    foreach (wdat[i]) wdat[i] = 8'($urandom);
    wr(8'h02, 4, 1'b1, 4, 0);
    for (int i = 0; i < 4; i++) mem[(2 + i) % 4] = wdat[i][5:0];
    mst.start();
    mst.send_byte({dev, 1'b0}, a);
    chk("busy_ack", {7'h00, a}, 8'h00);
    mst.stop();
    idle(LOCK + 20);
    setwr(8'h00);
    rd(5);
    // fifth byte spoils the burst
    foreach (wdat[i]) wdat[i] = 8'($urandom);
    wr(8'h01, 5, 1'b1, 4, LOCK + 20);
    setwr(8'h01);
    rd(4);
    // write protect
    wp = 1'b1;
    wr(8'h03, 1, 1'b1, 0, LOCK + 20);
    wp = 1'b0;
    setwr(8'h03);
    rd(2);
    // pin snapshot
    ext = 6'($urandom);
    setwr(8'hFF);
    rd(2);
    foreach (RSV[i]) wr(RSV[i], 0, 1'b0, 0, 10);
    // every byte and select-pin command, and pins command F2 only, under both select levels
    foreach (CMD[i]) begin
      for (int s = 0; s < 2; s++) begin
        sel = s[0];
        ext = 6'($urandom);
        wr(CMD[i], 0, 1'b1, 0, 10);
        src = (CMD[i][1:0] == 2'b00) ? 1 : (CMD[i][1] ? 2 : 0);
        sidx = int'(CMD[i][3:2]);
        chk_out();
      end
    end
    wr(8'hF2, 1, 1'b1, 0, 10);
    // reset in mid-run while the pins were forced
    ext = 6'h3F;
    sel = 1'b0;
    do_reset();
    chk_out();
    rd(1);
    finish_test();
  end
endmodule // tb
